// ===== logic/bpsc_pkg.sv
/*
  Package for the bridge PWM shutdown control block: register offsets,
  field positions, reset values, mode codes and the pin carrier type.
  Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
*/
package bpsc_pkg;

  // register byte offsets
  localparam logic [7:0] BPSC_UNIT_CTRL_OFS = 8'h00;
  localparam logic [7:0] BPSC_ASD_CTRL_OFS = 8'h04;
  localparam logic [7:0] BPSC_PWM_CTRL_OFS = 8'h08;
  localparam logic [7:0] BPSC_STATUS_OFS = 8'h0C;

  // reset values
  localparam logic [7:0] BPSC_UNIT_CTRL_RST = 8'h00;
  localparam logic [7:0] BPSC_ASD_CTRL_RST = 8'h00;
  localparam logic [7:0] BPSC_PWM_CTRL_RST = 8'h00;

  // unit_control_register fields
  localparam int BPSC_CFG_LSB = 6;
  localparam int BPSC_DIR_BIT = 7;
  localparam int BPSC_MODE_EN_MSB = 3;
  localparam int BPSC_MODE_EN_LSB = 2;
  localparam int BPSC_POL_AC_BIT = 1;
  localparam int BPSC_POL_BD_BIT = 0;

  // auto_shutdown_control fields
  localparam int BPSC_ASE_BIT = 7;
  localparam int BPSC_SRC_LSB = 4;
  localparam int BPSC_PAIR_AC_SHUTDOWN_STATE_LSB = 2;
  localparam int BPSC_PAIR_BD_SHUTDOWN_STATE_LSB = 0;

  // pwm_control_register fields
  localparam int BPSC_AUTO_RESTART_ENABLE_BIT = 7;

  // status register fields
  localparam int BPSC_PTF_BIT = 0;
  localparam int BPSC_DIR_APPLIED_BIT = 1;
  localparam int BPSC_RUN_BIT = 2;

  typedef enum logic [1:0]
  {
    BPSC_CFG_SINGLE = 2'b00,
    BPSC_CFG_FULL_FWD = 2'b01,
    BPSC_CFG_HALF = 2'b10,
    BPSC_CFG_FULL_REV = 2'b11
  } bpsc_cfg_t;

  // one bit per output pin
  typedef struct packed
  {
    logic d;
    logic c;
    logic b;
    logic a;
  } bpsc_pins_t;

endpackage

// ===== logic/bpsc_sync.sv
/*
  Two-flop synchroniser for a bundle of asynchronous levels.
  Assumes inputs are quasi-static levels; no edge information kept.
*/
`timescale 1ns/1ns
module bpsc_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  initial
  begin
    if (WIDTH < 1)
    begin
      $error("bpsc_sync: WIDTH must be at least 1");
    end
  end

  logic [WIDTH-1:0] stage1_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stage1_r <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1_r <= async_in;
      sync_out <= stage1_r;
    end
  end

endmodule

// ===== logic/bpsc_top.sv
/*
  Output stage of an enhanced PWM unit: full-bridge direction change,
  pair polarity, start-up ordering and level-driven auto-shutdown with
  forced pin states, reached over AHB-Lite.
  Assumes period_start and pwm_wave come from the period timer on hclk;
  the interrupt pin and comparator levels are asynchronous.
*/
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
module bpsc_top
  import bpsc_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // period timer and modulator
  input wire logic period_start,
  input wire logic pwm_wave,
  // shutdown sources
  input wire logic ext_interrupt_pin_0,
  input wire logic comparator_one_output,
  input wire logic comparator_two_output,
  // bridge pins
  output bpsc_pins_t pwm_out_o,
  output bpsc_pins_t pwm_out_oe
);

  // registers
  logic [7:0] unit_ctrl_r;
  logic [7:0] asd_ctrl_r;
  logic [7:0] pwm_ctrl_r;
  logic ptf_r;
  logic started_r;
  logic run_r;
  logic dir_applied_r;
  bpsc_pins_t drv_r;
  bpsc_pins_t drv_oe_r;
  logic [7:0] addr_r;
  logic wr_r;
  logic [31:0] rdata_r;

  // bus decode
  wire bus_take = hsel & htrans[1] & hready;
  wire wr_unit = wr_r & (addr_r == BPSC_UNIT_CTRL_OFS);
  wire wr_asd = wr_r & (addr_r == BPSC_ASD_CTRL_OFS);
  wire wr_pwm = wr_r & (addr_r == BPSC_PWM_CTRL_OFS);
  wire wr_stat = wr_r & (addr_r == BPSC_STATUS_OFS);

  // configuration fields
  wire [1:0] cfg = unit_ctrl_r[BPSC_CFG_LSB +: 2];
  wire cfg_dir = unit_ctrl_r[BPSC_DIR_BIT];
  wire pwm_en = &unit_ctrl_r[BPSC_MODE_EN_MSB:BPSC_MODE_EN_LSB];
  wire inv_ac = unit_ctrl_r[BPSC_POL_AC_BIT];
  wire inv_bd = unit_ctrl_r[BPSC_POL_BD_BIT];
  wire [2:0] src_sel = asd_ctrl_r[BPSC_SRC_LSB +: 3];
  wire [1:0] pss_ac = asd_ctrl_r[BPSC_PAIR_AC_SHUTDOWN_STATE_LSB +: 2];
  wire [1:0] pss_bd = asd_ctrl_r[BPSC_PAIR_BD_SHUTDOWN_STATE_LSB +: 2];
  wire ase = asd_ctrl_r[BPSC_ASE_BIT];
  wire auto_restart_enable = pwm_ctrl_r[BPSC_AUTO_RESTART_ENABLE_BIT];
  wire full_bridge = cfg[0];

  // source selection, shared by the raw and synchronised paths
  function automatic logic src_hit(input logic [2:0] sel, input logic int_n,
                                   input logic c1, input logic c2);
    src_hit = (sel[2] & ~int_n) | (sel[0] & c1) | (sel[1] & c2);
  endfunction

  // raw levels force the pins directly
  wire src_raw = src_hit(src_sel, ext_interrupt_pin_0, comparator_one_output,
                         comparator_two_output);

  // synchronised levels drive the status bit
  logic [2:0] src_sync;

  bpsc_sync #(
    .WIDTH(3)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({comparator_two_output, comparator_one_output, ext_interrupt_pin_0}),
    .sync_out(src_sync)
  );

  wire src_act = src_hit(src_sel, src_sync[0], src_sync[1], src_sync[2]);

  // status bit: source sets and wins; auto-restart clears; software
  // may write only while no condition is present and auto-restart is off
  wire ase_nxt = src_act ? 1'b1 :
                 auto_restart_enable ? 1'b0 :
                 wr_asd ? hwdata[BPSC_ASE_BIT] : ase;
  wire [7:0] asd_nxt = wr_asd ? {ase_nxt, hwdata[6:0]} : {ase_nxt, asd_ctrl_r[6:0]};

  // pins forced while status set or a selected level is present
  wire force_sd = pwm_en & (ase | src_raw);

  // run state: restart and direction applied only at a period start
  wire run_nxt = (ase | ~pwm_en) ? 1'b0 : (period_start ? 1'b1 : run_r);
  wire dir_nxt = (period_start & full_bridge) ? cfg_dir : dir_applied_r;
  wire dir_pending = full_bridge & (cfg_dir != dir_applied_r);

  // period flag: the first start opens a period, later ones close one
  wire started_nxt = pwm_en & (started_r | period_start);
  wire ptf_set = pwm_en & period_start & started_r;
  wire ptf_nxt = ptf_set | (ptf_r & ~(wr_stat & hwdata[BPSC_PTF_BIT]));

  // active-high output levels before polarity
  bpsc_pins_t act;

  always_comb
  begin
    act = '0;
    if (run_r)
    begin
      case (cfg)
        BPSC_CFG_SINGLE:
        begin
          act.a = pwm_wave;
        end
        BPSC_CFG_HALF:
        begin
          act.a = pwm_wave;
          act.b = ~pwm_wave;
        end
        BPSC_CFG_FULL_FWD, BPSC_CFG_FULL_REV:
        begin
          if (dir_pending)
          begin
            act.a = ~cfg_dir;
            act.c = cfg_dir;
          end
          else if (!dir_applied_r)
          begin
            act.a = 1'b1;
            act.d = pwm_wave;
          end
          else
          begin
            act.c = 1'b1;
            act.b = pwm_wave;
          end
        end
        default:
        begin
          act = '0;
        end
      endcase
    end
  end

  // pins in use per output configuration
  wire [3:0] used = full_bridge ? 4'hF : (cfg[1] ? 4'h3 : 4'h1);

  wire bpsc_pins_t drv_nxt = '{
    d: act.d ^ inv_bd,
    c: act.c ^ inv_ac,
    b: act.b ^ inv_bd,
    a: act.a ^ inv_ac
  };

  wire bpsc_pins_t oe_nxt = pwm_en ? bpsc_pins_t'(used) : '0;

  // shutdown pin states
  wire sd_ac_oe = ~pss_ac[1];
  wire sd_bd_oe = ~pss_bd[1];
  wire bpsc_pins_t sd_o = '{d: pss_bd[0], c: pss_ac[0], b: pss_bd[0], a: pss_ac[0]};
  wire bpsc_pins_t sd_oe = '{d: sd_bd_oe, c: sd_ac_oe, b: sd_bd_oe, a: sd_ac_oe};

  // shutdown overrides the registered drive without waiting for hclk
  assign pwm_out_o = force_sd ? (sd_o & drv_oe_r) : drv_r;
  assign pwm_out_oe = force_sd ? (sd_oe & drv_oe_r) : drv_oe_r;

  // read data mux
  wire [7:0] stat_rd = {5'h00, run_r, dir_applied_r, ptf_r};
  wire [7:0] rd_sel = (haddr == BPSC_UNIT_CTRL_OFS) ? unit_ctrl_r :
                      (haddr == BPSC_ASD_CTRL_OFS) ? asd_ctrl_r :
                      (haddr == BPSC_PWM_CTRL_OFS) ? pwm_ctrl_r :
                      (haddr == BPSC_STATUS_OFS) ? stat_rd : 8'h00;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_r <= 8'h00;
      wr_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      addr_r <= haddr;
      wr_r <= bus_take & hwrite;
      rdata_r <= (bus_take & ~hwrite) ? {24'h00_0000, rd_sel} : rdata_r;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign hrdata = rdata_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      unit_ctrl_r <= BPSC_UNIT_CTRL_RST;
      asd_ctrl_r <= BPSC_ASD_CTRL_RST;
      pwm_ctrl_r <= BPSC_PWM_CTRL_RST;
    end
    else
    begin
      unit_ctrl_r <= wr_unit ? hwdata[7:0] : unit_ctrl_r;
      asd_ctrl_r <= asd_nxt;
      pwm_ctrl_r <= wr_pwm ? hwdata[7:0] : pwm_ctrl_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      run_r <= 1'b0;
      dir_applied_r <= 1'b0;
      started_r <= 1'b0;
      ptf_r <= 1'b0;
      drv_r <= '0;
      drv_oe_r <= '0;
    end
    else
    begin
      run_r <= run_nxt;
      dir_applied_r <= dir_nxt;
      started_r <= started_nxt;
      ptf_r <= ptf_nxt;
      drv_r <= drv_nxt;
      drv_oe_r <= oe_nxt;
    end
  end

endmodule

// ===== sim/bpsc_bridge_model.sv
/* bridge switch driver inputs as the board sees them.
   assumes pull-downs hold a pin low while nobody drives it. */
`timescale 1ns/1ns
module bpsc_bridge_model
  import bpsc_pkg::*;
(
  // pins from the block
  input wire bpsc_pins_t pin_o,
  input wire bpsc_pins_t pin_oe,
  // resolved levels
  output bpsc_pins_t pin_lvl
);
  assign pin_lvl = pin_o & pin_oe;
endmodule

// ===== sim/bpsc_top_props.sv
/* port checker for bpsc_top, bound to every instance.
   assumes one slave, so hready follows hreadyout. */
`timescale 1ns/1ns
module bpsc_top_props
  import bpsc_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // timer and sources
  input wire logic period_start,
  input wire logic pwm_wave,
  input wire logic ext_interrupt_pin_0,
  input wire logic comparator_one_output,
  input wire logic comparator_two_output,
  // pins
  input wire bpsc_pins_t pwm_out_o,
  input wire bpsc_pins_t pwm_out_oe
);
  logic [7:0] ad_r, cf_r, as_r;
  logic wp_r, pd_r, ru_r;
  wire wu = wp_r && ad_r == BPSC_UNIT_CTRL_OFS;
  wire en = cf_r[3:2] == 2'h3;
  wire hit = (as_r[4] & comparator_one_output) | (as_r[5] & comparator_two_output)
    | (as_r[6] & ~ext_interrupt_pin_0);
  wire fl = en && cf_r[6] && hit;
  wire fw = en && ru_r && as_r == 8'h00 && cf_r[7:6] == 2'h1;
  wire rv = en && ru_r && as_r == 8'h00 && cf_r[7:6] == 2'h3;
  // shadow of written configuration, pending direction and run state
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      {wp_r, pd_r, ru_r} <= 3'h0;
      {ad_r, cf_r, as_r} <= 24'h0;
    end
    else
    begin
      wp_r <= hsel & htrans[1] & hready & hwrite;
      ad_r <= haddr;
      if (wu)
        cf_r <= hwdata[7:0];
      if (wp_r && ad_r == BPSC_ASD_CTRL_OFS)
        as_r <= hwdata[7:0];
      pd_r <= (wu && cf_r[6] && hwdata[6] && hwdata[7] != cf_r[7]) | (pd_r & ~period_start);
      ru_r <= en & (as_r == 8'h00) & (ru_r | period_start);
    end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_fw2;
    fw [*2];
  endsequence
  sequence s_pd2;
    (pd_r && en && ru_r && as_r == 8'h00) [*2];
  endsequence
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_zero_wait: assert property ($past(hresetn) |-> hreadyout)
    else $error("wait state inserted");
  a_ac_state: assert property (
    fl |-> {pwm_out_oe.a, pwm_out_oe.c} == {2{!as_r[3]}}
    && (as_r[3] || {pwm_out_o.a, pwm_out_o.c} == {2{as_r[2]}}))
    else $error("pair a c not in shutdown state");
  a_bd_state: assert property (
    fl |-> {pwm_out_oe.b, pwm_out_oe.d} == {2{!as_r[1]}}
    && (as_r[1] || {pwm_out_o.b, pwm_out_o.d} == {2{as_r[0]}}))
    else $error("pair b d not in shutdown state");
  a_fwd_idle: assert property (
    s_fw2 |-> pwm_out_o.b == cf_r[0] && pwm_out_o.c == cf_r[1])
    else $error("forward idle pins active");
  a_rev_idle: assert property (
    rv [*2] |-> pwm_out_o.a == cf_r[1] && pwm_out_o.d == cf_r[0])
    else $error("reverse idle pins active");
  a_fwd_mod: assert property (
    (fw && !pd_r) [*2] |-> pwm_out_o.d == ($past(pwm_wave) ^ cf_r[0]))
    else $error("forward modulation delayed");
  a_dir_hold: assert property (
    s_pd2 |-> pwm_out_o.b == cf_r[0] && pwm_out_o.d == cf_r[0]
    && pwm_out_o.c == (cf_r[1] ^ cf_r[7]))
    else $error("direction change sequence wrong");
endmodule
bind bpsc_top bpsc_top_props u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hreadyout, .hresp, .period_start, .pwm_wave, .ext_interrupt_pin_0,
  .comparator_one_output, .comparator_two_output, .pwm_out_o, .pwm_out_oe);

// ===== sim/bpsc_top_tb_top.sv
/* bench for bpsc_top: bus master, timer pulses, source levels.
   assumes a single slave whose hreadyout is the bus hready. */
`timescale 1ns/1ns
module bpsc_top_tb_top;
  import bpsc_pkg::*;
  logic hclk = 1'h0, hresetn = 1'h0, hwrite = 1'h0, ps = 1'h0, wv = 1'h0;
  logic i0 = 1'h1, c1 = 1'h0, c2 = 1'h0, hreadyout, hresp;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, q;
  bpsc_pins_t po, oe, lv;
  int err_total = 0, checks_done = 0;
  bpsc_top DUT (.hclk, .hresetn, .hsel(1'h1), .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .period_start(ps),
    .pwm_wave(wv), .ext_interrupt_pin_0(i0), .comparator_one_output(c1),
    .comparator_two_output(c2), .pwm_out_o(po), .pwm_out_oe(oe));
  bpsc_bridge_model u_br (.pin_o(po), .pin_oe(oe), .pin_lvl(lv));
  initial
  begin
    forever #20 hclk = ~hclk;
  end
  task automatic tally_and_finish;
    if (err_total == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] v, e);
    checks_done++;
    if (v !== e)
    begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", n, e, v);
    end
  endtask
  task automatic rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'h1)
    begin
      n++;
      if (n > 20)
      begin
        err_total++;
        tally_and_finish;
      end
      @(posedge hclk);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    q = hrdata;
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'h0, 32'h0);
    chk(n, q, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // pins settle after the edge; judged at the falling edge
  task automatic pins(input string n, input logic [7:0] e);
    @(negedge hclk);
    chk(n, {oe, lv}, e);
    @(posedge hclk);
  endtask
  task automatic pulse;
    ps <= 1'h1;
    @(posedge hclk);
    ps <= 1'h0;
    @(posedge hclk);
  endtask
  task automatic t_regs;
    rc("asd", BPSC_ASD_CTRL_OFS, {24'h0, BPSC_ASD_CTRL_RST});
    rc("pwmc", BPSC_PWM_CTRL_OFS, {24'h0, BPSC_PWM_CTRL_RST});
    bus(8'h10, 1'h1, 32'hFF);
    rc("unmap", 8'h10, 32'h0);
  endtask
  task automatic t_fwd;
    bus(BPSC_UNIT_CTRL_OFS, 1'h1, 32'h4E);
    pulse;
    rc("ptf1", BPSC_STATUS_OFS, 32'h4);
    pulse;
    rc("ptf2", BPSC_STATUS_OFS, 32'h5);
    wv <= 1'h1;
    cyc(1);
    pins("fwd1", 8'hFC);
    wv <= 1'h0;
    cyc(1);
    pins("fwd0", 8'hF4);
  endtask
  task automatic t_dir;
    bus(BPSC_UNIT_CTRL_OFS, 1'h1, 32'hCE);
    wv <= 1'h1;
    cyc(1);
    pins("pend", 8'hF1);
    rc("dirq", BPSC_STATUS_OFS, 32'h5);
    pulse;
    cyc(1);
    pins("rev", 8'hF3);
  endtask
  task automatic t_sd;
    bus(BPSC_ASD_CTRL_OFS, 1'h1, 32'h16);
    c1 <= 1'h1;
    pins("force", 8'h55);
    cyc(4);
    rc("ase", BPSC_ASD_CTRL_OFS, 32'h96);
    bus(BPSC_ASD_CTRL_OFS, 1'h1, 32'h16);
    rc("lock", BPSC_ASD_CTRL_OFS, 32'h96);
    c1 <= 1'h0;
    cyc(4);
    pins("stick", 8'h55);
    bus(BPSC_ASD_CTRL_OFS, 1'h1, 32'h16);
    cyc(1);
    pins("idle", 8'hF5);
    pulse;
    cyc(1);
    pins("run", 8'hF3);
  endtask
  task automatic t_src;
    logic [2:0] s;
    for (int k = 0; k < 8; k++)
      for (int j = 0; j < 3; j++)
      begin
        s = 3'h1 << j;
        bus(BPSC_ASD_CTRL_OFS, 1'h1, k << 4);
        {i0, c2, c1} <= s ^ 3'h4;
        cyc(4);
        rc("src", BPSC_ASD_CTRL_OFS, {|(k & s), k[2:0], 4'h0});
        {i0, c2, c1} <= 3'h4;
        cyc(4);
        bus(BPSC_ASD_CTRL_OFS, 1'h1, 32'h0);
      end
  endtask
  task automatic t_ar;
    bus(BPSC_PWM_CTRL_OFS, 1'h1, 32'h80);
    bus(BPSC_ASD_CTRL_OFS, 1'h1, 32'hA0);
    cyc(1);
    rc("swsd", BPSC_ASD_CTRL_OFS, 32'h20);
    c2 <= 1'h1;
    cyc(4);
    rc("hold", BPSC_ASD_CTRL_OFS, 32'hA0);
    c2 <= 1'h0;
    cyc(4);
    rc("auto", BPSC_ASD_CTRL_OFS, 32'h20);
  endtask
  // half bridge with b/d active-low, then single output
  task automatic t_modes;
    bus(BPSC_UNIT_CTRL_OFS, 1'h1, 32'h8D);
    pulse;
    wv <= 1'h1;
    cyc(1);
    pins("half", 8'h33);
    bus(BPSC_UNIT_CTRL_OFS, 1'h1, 32'h0C);
    cyc(1);
    pins("single", 8'h11);
  endtask
  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    t_regs;
    t_fwd;
    t_dir;
    t_sd;
    t_src;
    t_ar;
    t_modes;
    tally_and_finish;
  end
endmodule
